// ===== logic/hsf_framer_status.sv
// Status flags of one framer's link controllers
`timescale 1ns/1ps
`default_nettype none

module hsf_framer_status #(
    parameter int unsigned FIFO_DEPTH = hsf_pkg::FIFO_DEPTH,
    parameter int unsigned LW = $clog2(FIFO_DEPTH + 1)
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic rx_code_detected,
    input wire logic rx_msg_ok,
    input wire logic rx_crc_error,
    input wire logic rx_overrun,
    input wire logic rx_abort,
    input wire logic rx_open_byte,
    input wire logic [LW-1:0] rx_fifo_level,
    input wire logic [LW-1:0] tx_fifo_level,
    input wire logic tx_msg_done,
    input wire logic read_clear,
    output logic [7:0] status
);

    typedef struct packed {
        logic code_prev;
        logic [7:0] flags;
    } hsf_framer_state_t;

    hsf_framer_state_t r;
    hsf_framer_state_t n;

    // Half-way mark; an odd depth has no clean half
    localparam logic [LW-1:0] HALF = LW'(FIFO_DEPTH / 2);
    localparam logic [LW-1:0] FULL = LW'(FIFO_DEPTH);

    if (FIFO_DEPTH < 2 || (FIFO_DEPTH % 2) != 0
            || LW < $clog2(FIFO_DEPTH + 1)) begin : g_bad_depth
        $error("FIFO depth must be even, at least two, and fit LW bits");
    end

    function automatic logic at_least(logic [LW-1:0] lvl,
                                      logic [LW-1:0] thr);
        return lvl >= thr;
    endfunction

    // *****************************************************
    // Flag update
    // *****************************************************
    // Latched flags: a set in the clearing cycle survives
    always_comb begin
        logic [7:0] set;
        logic [7:0] kept;
        set = 8'h00;
        kept = read_clear ? 8'h00 : r.flags;
        n = r;
        n.code_prev = rx_code_detected;
        set[hsf_pkg::CODE_CHG_BIT] = rx_code_detected ^ r.code_prev; // R2
        set[hsf_pkg::PKT_END_BIT] = rx_msg_ok // R3
            | rx_crc_error | rx_overrun | rx_abort; // R4
        set[hsf_pkg::PKT_START_BIT] = rx_open_byte; // R5
        set[hsf_pkg::TX_DONE_BIT] = tx_msg_done; // R9
        n.flags = (kept | set) & hsf_pkg::LATCHED_BITS; // R10
        // Level flags follow the FIFOs, never held
        n.flags[hsf_pkg::RX_HALF_BIT] = at_least(rx_fifo_level, HALF); // R12 R13
        n.flags[hsf_pkg::RX_NE_BIT] = at_least(rx_fifo_level, LW'(1)); // R6
        n.flags[hsf_pkg::TX_HALF_BIT] = !at_least(tx_fifo_level, HALF); // R7
        n.flags[hsf_pkg::TX_NF_BIT] = !at_least(tx_fifo_level, FULL); // R8
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{code_prev: 1'b0, flags: hsf_pkg::STATUS_RESET};
        end else begin
            r <= n;
        end
    end

    assign status = r.flags;

    // *****************************************************
    // Checks
    // *****************************************************
    property p_code_change;
        @(posedge sys_clk) disable iff (!rst_n)
        (rx_code_detected != r.code_prev) |=> status[7];
    endproperty
    a_code_change: assert property (p_code_change) // R2
        else $error("code change not flagged");

    property p_pkt_end;
        @(posedge sys_clk) disable iff (!rst_n)
        (rx_msg_ok || rx_crc_error || rx_overrun || rx_abort) |=> status[6];
    endproperty
    a_pkt_end: assert property (p_pkt_end) // R4
        else $error("packet end not flagged");

    property p_hold_until_read;
        @(posedge sys_clk) disable iff (!rst_n)
        (status[5] && !read_clear) |=> status[5];
    endproperty
    a_hold_until_read: assert property (p_hold_until_read) // R10
        else $error("packet start flag lost before read");

    property p_read_clears;
        @(posedge sys_clk) disable iff (!rst_n)
        (read_clear && !tx_msg_done) |=> !status[0];
    endproperty
    a_read_clears: assert property (p_read_clears) // R10
        else $error("message done flag not cleared by read");

    property p_rx_levels;
        @(posedge sys_clk) disable iff (!rst_n)
        // Sampled reset gate: the release edge still shows reset flags
        rst_n |=> (status[3] == ($past(rx_fifo_level) != '0))
            && (status[4] == ($past(rx_fifo_level) >= HALF));
    endproperty
    a_rx_levels: assert property (p_rx_levels) // R13
        else $error("receive FIFO flags do not track level");

    property p_tx_levels;
        @(posedge sys_clk) disable iff (!rst_n)
        rst_n |=> (status[2] == ($past(tx_fifo_level) < HALF))
            && (status[1] == ($past(tx_fifo_level) < FULL));
    endproperty
    a_tx_levels: assert property (p_tx_levels) // R7
        else $error("transmit FIFO flags do not track level");

endmodule
`default_nettype wire

// ===== logic/hsf_pkg.sv
// Package: addresses, bit positions and reset values of the status flags
package hsf_pkg;

    // *****************************************************
    // Register addresses on the parallel control port
    // *****************************************************
    localparam logic [7:0] STATUS_A_ADDR = 8'h01;
    localparam logic [7:0] MASK_A_ADDR = 8'h02;
    localparam logic [7:0] STATUS_B_ADDR = 8'hA1;
    localparam logic [7:0] MASK_B_ADDR = 8'hA2;

    // *****************************************************
    // Status bit positions
    // *****************************************************
    localparam int unsigned CODE_CHG_BIT = 7;
    localparam int unsigned PKT_END_BIT = 6;
    localparam int unsigned PKT_START_BIT = 5;
    localparam int unsigned RX_HALF_BIT = 4;
    localparam int unsigned RX_NE_BIT = 3;
    localparam int unsigned TX_HALF_BIT = 2;
    localparam int unsigned TX_NF_BIT = 1;
    localparam int unsigned TX_DONE_BIT = 0;

    // Bits that hold until read; the rest track the FIFOs
    localparam logic [7:0] LATCHED_BITS = 8'hE1;

    // *****************************************************
    // Reset values and sizes
    // *****************************************************
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] IDLE_DATA = 8'h00;
    localparam int unsigned FIFO_DEPTH = 64;
    localparam int unsigned FRAMERS = 2;

    // Access state of the control port
    typedef enum logic [1:0] {
        HSF_IDLE,
        HSF_READ,
        HSF_WRITE
    } hsf_port_state_t;

endpackage

// ===== logic/hsf_status_flags.sv
// Top: link controller status and mask registers for both framers
//
// Function
// R1: Two status registers exist, framer A at 01h and framer B at A1h.
// R2: Bit 7 sets when the code detector gains or loses a valid code.
// R3: Bit 6 sets when a received message completes its CRC check.
// R4: Bit 6 also sets on a CRC error, receive overrun or abort.
// R5: Bit 5 sets when the receiver sees the opening byte of a packet.
// R6: Bit 3 is set while the receive FIFO holds at least one byte.
// R7: Bit 2 is set while the transmit FIFO is below half full.
// R8: Bit 1 is set while the transmit FIFO has room for one more byte.
// R9: Bit 0 sets when the transmitter has finished a message.
// R10: Bits 7, 6, 5 and 0 hold once set and clear when the register is read.
// R11: Each framer has a same-layout mask register, framer A at 02h.
// R12: Bit 4 is set while the receive FIFO is at or past half full.
// R13: Bits 4 to 1 follow the FIFO state and are never held.
`timescale 1ns/1ps
`default_nettype none

module hsf_status_flags #(
    parameter int unsigned FIFO_DEPTH = hsf_pkg::FIFO_DEPTH,
    parameter int unsigned LW = $clog2(FIFO_DEPTH + 1)
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic cpu_cs_n,
    input wire logic cpu_rd_n,
    input wire logic cpu_wr_n,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_data_in,
    output logic [7:0] cpu_data_out,
    output logic cpu_data_oe_n,
    input wire logic [1:0] rx_code_detected,
    input wire logic [1:0] rx_msg_ok,
    input wire logic [1:0] rx_crc_error,
    input wire logic [1:0] rx_overrun,
    input wire logic [1:0] rx_abort,
    input wire logic [1:0] rx_open_byte,
    input wire logic [1:0][LW-1:0] rx_fifo_level,
    input wire logic [1:0][LW-1:0] tx_fifo_level,
    input wire logic [1:0] tx_msg_done,
    output logic [7:0] link_irq_mask_framer_a,
    output logic [7:0] link_irq_mask_framer_b,
    output logic [7:0] pending_framer_a,
    output logic [7:0] pending_framer_b
);

    // *****************************************************
    // Types and storage
    // *****************************************************
    typedef struct packed {
        logic [2:0] cs_sync;
        logic [2:0] rd_sync;
        logic [2:0] wr_sync;
        logic cs_f;
        logic rd_f;
        logic wr_f;
        hsf_pkg::hsf_port_state_t state;
        logic [7:0] addr_q;
        logic [7:0] rdata;
        logic oe_n;
        logic [7:0] mask_a;
        logic [7:0] mask_b;
        logic [7:0] pend_a;
        logic [7:0] pend_b;
    } hsf_top_state_t;

    hsf_top_state_t r;
    hsf_top_state_t n;
    logic [1:0] rst_sync;
    logic rst_n;
    logic [1:0] read_clear;
    logic [7:0] status [2];
    logic rd_go;
    logic wr_go;

    // True for every address this block answers
    function automatic logic addr_mapped(logic [7:0] a);
        return a == hsf_pkg::STATUS_A_ADDR || a == hsf_pkg::MASK_A_ADDR
            || a == hsf_pkg::STATUS_B_ADDR || a == hsf_pkg::MASK_B_ADDR;
    endfunction

    // *****************************************************
    // Reset release
    // *****************************************************
    // Assertion is immediate, release waits two clock edges
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    // *****************************************************
    // Per-framer flag logic
    // *****************************************************
    // Index 0 serves framer A, index 1 framer B
    for (genvar i = 0; i < hsf_pkg::FRAMERS; i++) begin : g_framer // R1
        hsf_framer_status #(
            .FIFO_DEPTH(FIFO_DEPTH),
            .LW(LW)
        ) u_flags (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .rx_code_detected(rx_code_detected[i]),
            .rx_msg_ok(rx_msg_ok[i]),
            .rx_crc_error(rx_crc_error[i]),
            .rx_overrun(rx_overrun[i]),
            .rx_abort(rx_abort[i]),
            .rx_open_byte(rx_open_byte[i]),
            .rx_fifo_level(rx_fifo_level[i]),
            .tx_fifo_level(tx_fifo_level[i]),
            .tx_msg_done(tx_msg_done[i]),
            .read_clear(read_clear[i]),
            .status(status[i])
        );
    end

    // *****************************************************
    // Control port
    // *****************************************************
    // Strobes are asynchronous pins: three flops, and a level
    // counts once the second and third agree. Address and
    // write data must stay steady for the whole strobe, and write
    // data until a few clocks past its end, since they are sampled a few clocks after its edges.
    always_comb begin
        n = r;
        read_clear = 2'b00;
        n.cs_sync = {r.cs_sync[1:0], ~cpu_cs_n};
        n.rd_sync = {r.rd_sync[1:0], ~cpu_rd_n};
        n.wr_sync = {r.wr_sync[1:0], ~cpu_wr_n};
        if (r.cs_sync[1] == r.cs_sync[2]) begin
            n.cs_f = r.cs_sync[2];
        end
        if (r.rd_sync[1] == r.rd_sync[2]) begin
            n.rd_f = r.rd_sync[2];
        end
        if (r.wr_sync[1] == r.wr_sync[2]) begin
            n.wr_f = r.wr_sync[2];
        end
        rd_go = r.cs_f & r.rd_f;
        wr_go = r.cs_f & r.wr_f;
        // Pending view lets outside interrupt logic use the masks
        n.pend_a = status[0] & r.mask_a; // R11
        n.pend_b = status[1] & r.mask_b;
        unique case (r.state)
            hsf_pkg::HSF_IDLE: begin
                if (rd_go) begin
                    n.addr_q = cpu_addr;
                    n.oe_n = ~addr_mapped(cpu_addr);
                    n.state = hsf_pkg::HSF_READ;
                    // Capture and clear in one edge: nothing lost
                    unique case (cpu_addr)
                        hsf_pkg::STATUS_A_ADDR: begin // R1
                            n.rdata = status[0];
                            read_clear[0] = 1'b1; // R10
                        end
                        hsf_pkg::STATUS_B_ADDR: begin // R1
                            n.rdata = status[1];
                            read_clear[1] = 1'b1; // R10
                        end
                        hsf_pkg::MASK_A_ADDR: begin
                            n.rdata = r.mask_a; // R11
                        end
                        hsf_pkg::MASK_B_ADDR: begin
                            n.rdata = r.mask_b;
                        end
                        default: begin
                            n.rdata = hsf_pkg::IDLE_DATA;
                        end
                    endcase
                end else if (wr_go) begin
                    n.addr_q = cpu_addr;
                    n.state = hsf_pkg::HSF_WRITE;
                end
            end
            hsf_pkg::HSF_READ: begin
                if (!rd_go) begin
                    n.oe_n = 1'b1;
                    n.state = hsf_pkg::HSF_IDLE;
                end
            end
            hsf_pkg::HSF_WRITE: begin
                // Write lands at the trailing edge, when data is valid;
                // status registers ignore writes
                if (!wr_go) begin
                    if (r.addr_q == hsf_pkg::MASK_A_ADDR) begin
                        n.mask_a = cpu_data_in; // R11
                    end
                    if (r.addr_q == hsf_pkg::MASK_B_ADDR) begin
                        n.mask_b = cpu_data_in;
                    end
                    n.state = hsf_pkg::HSF_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{
                cs_sync: 3'h0, rd_sync: 3'h0, wr_sync: 3'h0,
                cs_f: 1'b0, rd_f: 1'b0, wr_f: 1'b0,
                state: hsf_pkg::HSF_IDLE,
                addr_q: 8'h00, rdata: hsf_pkg::IDLE_DATA, oe_n: 1'b1,
                mask_a: hsf_pkg::MASK_RESET, mask_b: hsf_pkg::MASK_RESET,
                pend_a: 8'h00, pend_b: 8'h00
            };
        end else begin
            r <= n;
        end
    end

    // Outputs straight from flops
    assign cpu_data_out = r.rdata;
    assign cpu_data_oe_n = r.oe_n;
    assign link_irq_mask_framer_a = r.mask_a;
    assign link_irq_mask_framer_b = r.mask_b;
    assign pending_framer_a = r.pend_a;
    assign pending_framer_b = r.pend_b;

    // *****************************************************
    // Checks
    // *****************************************************
    sequence s_read_at(logic [7:0] a);
        r.state == hsf_pkg::HSF_IDLE && rd_go && cpu_addr == a;
    endsequence

    sequence s_write_end(logic [7:0] a);
        r.state == hsf_pkg::HSF_WRITE && !wr_go && r.addr_q == a;
    endsequence

    property p_read_a;
        @(posedge sys_clk) disable iff (!rst_n)
        s_read_at(hsf_pkg::STATUS_A_ADDR)
            |=> cpu_data_out == $past(status[0]) && !cpu_data_oe_n;
    endproperty
    a_read_a: assert property (p_read_a) // R1
        else $error("status A read returned wrong data");

    property p_read_b;
        @(posedge sys_clk) disable iff (!rst_n)
        s_read_at(hsf_pkg::STATUS_B_ADDR)
            |=> cpu_data_out == $past(status[1]) && !cpu_data_oe_n;
    endproperty
    a_read_b: assert property (p_read_b) // R1
        else $error("status B read returned wrong data");

    property p_read_clears_a;
        @(posedge sys_clk) disable iff (!rst_n)
        s_read_at(hsf_pkg::STATUS_A_ADDR) ##0 !rx_open_byte[0]
            |=> !status[0][5];
    endproperty
    a_read_clears_a: assert property (p_read_clears_a) // R10
        else $error("packet start flag survived a read");

    property p_mask_write;
        @(posedge sys_clk) disable iff (!rst_n)
        s_write_end(hsf_pkg::MASK_A_ADDR)
            |=> link_irq_mask_framer_a == $past(cpu_data_in);
    endproperty
    a_mask_write: assert property (p_mask_write) // R11
        else $error("mask A write not stored");

    property p_unmapped_quiet;
        @(posedge sys_clk) disable iff (!rst_n)
        (r.state == hsf_pkg::HSF_IDLE && rd_go && !addr_mapped(cpu_addr))
            |=> cpu_data_oe_n [*2];
    endproperty
    a_unmapped_quiet: assert property (p_unmapped_quiet) // R1
        else $error("data bus driven for an unmapped address");

    property p_read_release;
        @(posedge sys_clk) disable iff (!rst_n)
        (r.state == hsf_pkg::HSF_READ && !rd_go) |=> cpu_data_oe_n;
    endproperty
    a_read_release: assert property (p_read_release) // R1
        else $error("data bus held after read strobe ended");

endmodule
`default_nettype wire

// ===== verification/hsf_status_flags_tb_top.sv
// Testbench for the link controller status and mask registers
`timescale 1ns/1ps
`default_nettype none

module hsf_status_flags_tb_top;

    // ***************************************************
    // Signals, sizes and counters
    // ***************************************************
    localparam int unsigned DEPTH = hsf_pkg::FIFO_DEPTH;
    localparam int unsigned LW = $clog2(DEPTH + 1);
    localparam int unsigned HALF = DEPTH / 2;
    localparam int unsigned CEILING = 20000;
    // Idle status: transmit FIFO empty, so half-empty and space are set
    localparam logic [7:0] IDLE_ST = 8'h06;

    logic sys_clk = 1'b0;
    logic reset_n;
    logic cpu_cs_n, cpu_rd_n, cpu_wr_n;
    logic [7:0] cpu_addr, cpu_data_in, cpu_data_out;
    logic cpu_data_oe_n;
    logic [1:0] rx_code_detected, rx_msg_ok, rx_crc_error, rx_overrun;
    logic [1:0] rx_abort, rx_open_byte, tx_msg_done;
    logic [1:0][LW-1:0] rx_fifo_level, tx_fifo_level;
    logic [7:0] mask_a, mask_b, pend_a, pend_b;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;

    hsf_status_flags #(.FIFO_DEPTH(DEPTH), .LW(LW)) dut_u (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .cpu_cs_n(cpu_cs_n),
        .cpu_rd_n(cpu_rd_n),
        .cpu_wr_n(cpu_wr_n),
        .cpu_addr(cpu_addr),
        .cpu_data_in(cpu_data_in),
        .cpu_data_out(cpu_data_out),
        .cpu_data_oe_n(cpu_data_oe_n),
        .rx_code_detected(rx_code_detected),
        .rx_msg_ok(rx_msg_ok),
        .rx_crc_error(rx_crc_error),
        .rx_overrun(rx_overrun),
        .rx_abort(rx_abort),
        .rx_open_byte(rx_open_byte),
        .rx_fifo_level(rx_fifo_level),
        .tx_fifo_level(tx_fifo_level),
        .tx_msg_done(tx_msg_done),
        .link_irq_mask_framer_a(mask_a),
        .link_irq_mask_framer_b(mask_b),
        .pending_framer_a(pend_a),
        .pending_framer_b(pend_b)
    );

    // 20 MHz system clock
    always #25 sys_clk = ~sys_clk;

    // ***************************************************
    // Verdict and hang guard
    // ***************************************************
    task automatic close_out();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A stuck handshake would otherwise run forever
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == CEILING) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end

    // ***************************************************
    // Compare tasks
    // ***************************************************
    task automatic cmp8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp1(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    // ***************************************************
    // Control port accesses
    // ***************************************************
    // Strobes are held well past the three-flop filter on both edges
    task automatic chk_rd(input string what, input logic [7:0] a,
                          input logic oe_exp, input logic [7:0] exp);
        @(posedge sys_clk);
        cpu_addr <= a;
        cpu_cs_n <= 1'b0;
        cpu_rd_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        cmp1({what, "_oe_n"}, oe_exp, cpu_data_oe_n);
        if (oe_exp == 1'b0) begin
            cmp8(what, exp, cpu_data_out);
        end
        @(posedge sys_clk);
        cpu_cs_n <= 1'b1;
        cpu_rd_n <= 1'b1;
        repeat (7) @(posedge sys_clk);
        #1;
        cmp1({what, "_oe_n_after"}, 1'b1, cpu_data_oe_n);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cpu_addr <= a;
        cpu_data_in <= d;
        cpu_cs_n <= 1'b0;
        cpu_wr_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        cpu_cs_n <= 1'b1;
        cpu_wr_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask

    // One-cycle event pulse on framer f, then let the flag land
    task automatic pulse_evt(input int k, input int f);
        @(posedge sys_clk);
        case (k)
            0: rx_msg_ok[f] <= 1'b1;
            1: rx_crc_error[f] <= 1'b1;
            2: rx_overrun[f] <= 1'b1;
            3: rx_abort[f] <= 1'b1;
            4: rx_open_byte[f] <= 1'b1;
            default: tx_msg_done[f] <= 1'b1;
        endcase
        @(posedge sys_clk);
        rx_msg_ok <= 2'b00;
        rx_crc_error <= 2'b00;
        rx_overrun <= 2'b00;
        rx_abort <= 2'b00;
        rx_open_byte <= 2'b00;
        tx_msg_done <= 2'b00;
        repeat (3) @(posedge sys_clk);
    endtask

    function automatic logic [7:0] st_addr(input int f);
        return (f == 0) ? hsf_pkg::STATUS_A_ADDR : hsf_pkg::STATUS_B_ADDR;
    endfunction

    // ***************************************************
    // Main sequence
    // ***************************************************
    initial begin
        logic [7:0] bitv;
        logic [LW-1:0] rxl [5];
        logic [LW-1:0] txl [5];
        logic [7:0] lexp [5];
        rxl = '{LW'(0), LW'(1), LW'(HALF - 1), LW'(HALF), LW'(DEPTH)};
        txl = '{LW'(DEPTH), LW'(DEPTH - 1), LW'(HALF), LW'(HALF - 1),
                LW'(0)};
        lexp = '{8'h00, 8'h0A, 8'h0A, 8'h1E, 8'h1E};
        reset_n = 1'b0;
        cpu_cs_n = 1'b1;
        cpu_rd_n = 1'b1;
        cpu_wr_n = 1'b1;
        cpu_addr = 8'h00;
        cpu_data_in = 8'h00;
        rx_code_detected = 2'b00;
        rx_msg_ok = 2'b00;
        rx_crc_error = 2'b00;
        rx_overrun = 2'b00;
        rx_abort = 2'b00;
        rx_open_byte = 2'b00;
        tx_msg_done = 2'b00;
        rx_fifo_level = '0;
        tx_fifo_level = '0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge sys_clk);

        // Reset values, both framers, masks and an unmapped place
        chk_rd("status_a", hsf_pkg::STATUS_A_ADDR, 1'b0, IDLE_ST);
        chk_rd("status_b", hsf_pkg::STATUS_B_ADDR, 1'b0, IDLE_ST);
        chk_rd("mask_a", hsf_pkg::MASK_A_ADDR, 1'b0, 8'h00);
        chk_rd("mask_b", hsf_pkg::MASK_B_ADDR, 1'b0, 8'h00);
        chk_rd("unmapped", 8'h33, 1'b1, 8'h00);

        // Masks take writes; status ignores them
        wr(hsf_pkg::MASK_A_ADDR, 8'h41);
        wr(hsf_pkg::MASK_B_ADDR, 8'hA5);
        wr(hsf_pkg::STATUS_A_ADDR, 8'hFF);
        chk_rd("mask_a", hsf_pkg::MASK_A_ADDR, 1'b0, 8'h41);
        chk_rd("mask_b", hsf_pkg::MASK_B_ADDR, 1'b0, 8'hA5);
        cmp8("mask_a_out", 8'h41, mask_a);
        cmp8("mask_b_out", 8'hA5, mask_b);
        chk_rd("status_a", hsf_pkg::STATUS_A_ADDR, 1'b0, IDLE_ST);

        // Every latched event but the code change on each framer, the other framer untouched
        for (int f = 0; f < 2; f++) begin
            for (int k = 0; k < 6; k++) begin
                bitv = (k < 4) ? 8'h40 : ((k == 4) ? 8'h20 : 8'h01);
                pulse_evt(k, f);
                if (f == 0 && k == 0) begin
                    // Look after the edge; idle B still has bit 2 unmasked
                    #1;
                    cmp8("pending_a", 8'h40, pend_a);
                    cmp8("pending_b", IDLE_ST & 8'hA5, pend_b);
                end
                chk_rd("other", st_addr(1 - f), 1'b0, IDLE_ST);
                chk_rd("event", st_addr(f), 1'b0, IDLE_ST | bitv);
                chk_rd("cleared", st_addr(f), 1'b0, IDLE_ST);
            end
        end

        // Code detector gains, then loses, a valid code
        for (int f = 0; f < 2; f++) begin
            for (int lv = 1; lv >= 0; lv--) begin
                @(posedge sys_clk);
                rx_code_detected[f] <= lv[0];
                repeat (3) @(posedge sys_clk);
                chk_rd("code_chg", st_addr(f), 1'b0, 8'h86);
                chk_rd("code_clr", st_addr(f), 1'b0, IDLE_ST);
            end
        end

        // FIFO boundaries; flags follow the level and survive a read
        for (int f = 0; f < 2; f++) begin
            for (int i = 0; i < 5; i++) begin
                @(posedge sys_clk);
                rx_fifo_level[f] <= rxl[i];
                tx_fifo_level[f] <= txl[i];
                repeat (3) @(posedge sys_clk);
                chk_rd("level", st_addr(f), 1'b0, lexp[i]);
                chk_rd("level_again", st_addr(f), 1'b0, lexp[i]);
            end
            @(posedge sys_clk);
            rx_fifo_level[f] <= '0;
            tx_fifo_level[f] <= '0;
            repeat (3) @(posedge sys_clk);
            chk_rd("level_back", st_addr(f), 1'b0, IDLE_ST);
        end
        close_out();
    end

endmodule

`default_nettype wire
